// File: logic/lpw_pkg.sv
package lpw_pkg;

	// Register byte offsets on the Avalon-MM slave
	localparam logic [7:0] OFS_MODE  = 8'h00;
	localparam logic [7:0] OFS_SEF   = 8'h04;
	localparam logic [7:0] OFS_SES   = 8'h08;
	localparam logic [7:0] OFS_BOD   = 8'h0C;
	localparam logic [7:0] OFS_STAT  = 8'h10;
	localparam logic [7:0] OFS_CAUSE = 8'h14;

	// Low-power mode request codes
	localparam logic [1:0] MODE_ACTIVE = 2'h0;
	localparam logic [1:0] MODE_SLEEP  = 2'h1;
	localparam logic [1:0] MODE_DSLEEP = 2'h2;
	localparam logic [1:0] MODE_DPD    = 2'h3;

	// start_enable_first bit positions
	localparam int SEF_W         = 13;
	localparam int SEF_BOD       = 0;
	localparam int SEF_WDT       = 1;
	localparam int SEF_RTC_ALARM = 2;
	localparam int SEF_RTC_WAKE  = 3;
	localparam int SEF_MICROTICK_TIMER     = 4;
	localparam int SEF_I2C       = 5;
	localparam int SEF_SPI       = 6;
	localparam int SEF_UART      = 7;
	localparam int SEF_USB0      = 8;
	localparam int SEF_USB1      = 9;
	localparam int SEF_ETH       = 10;
	localparam int SEF_DMA       = 11;
	localparam int SEF_PINS      = 12;
	localparam int PIN_N         = 8;

	// brownout_control bits
	localparam int BOD_W       = 2;
	localparam int BOD_RST_EN  = 0;
	localparam int BOD_IRQ_EN  = 1;

	// Wake cause bits, write one to clear
	localparam int CAUSE_W      = 2;
	localparam int CAUSE_SLEEP  = 0;
	localparam int CAUSE_DSLEEP = 1;

	// Reset values
	localparam logic [SEF_W-1:0] SEF_RST   = 13'h0000;
	localparam logic [PIN_N-1:0] SES_RST   = 8'h00;
	localparam logic [BOD_W-1:0] BOD_RST   = 2'h0;

	// Domain reset sequence length after a power-down wake
	localparam int CLK_NS     = 50;
	localparam int RST_SEQ_NS = 1000;
	localparam int RST_SEQ_CYC = (RST_SEQ_NS + CLK_NS - 1) / CLK_NS;
	localparam int RST_CNT_W  = 6;

	typedef enum logic [4:0] {
		ST_ACTIVE = 5'h01,
		ST_SLEEP  = 5'h02,
		ST_DSLEEP = 5'h04,
		ST_DPD    = 5'h08,
		ST_RSTSEQ = 5'h10
	} lpw_state_type;

	typedef struct packed {
		logic cpuClkEn;
		logic periphClkEn;
		logic flashStandby;
		logic pllOn;
		logic ethClkEn;
		logic serialClkEn;
		logic domainPowerOn;
		logic pinHighZ;
		logic stateHold;
		logic domainReset;
	} lpw_power_type;

	typedef struct packed {
		logic             nvicIrq;
		logic             hardwareWake;
		logic [PIN_N-1:0] pinIrq;
		logic             brownoutIrq;
		logic             brownoutReset;
		logic             watchdogIrq;
		logic             watchdogReset;
		logic             microtickIrq;
		logic             rtcWakeTimeout;
		logic             i2cIrq;
		logic             i2cSlave;
		logic             spiIrq;
		logic             spiSlave;
		logic             uartIrq;
		logic             uartSyncSlave;
		logic             uart32k;
		logic             usb0NeedClk;
		logic             usb1NeedClk;
		logic             ethIrq;
		logic             dmaIrq;
	} lpw_wake_src_type;

endpackage

// File: logic/lpw_wake_ctrl.sv
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/100ps

module lpw_wake_ctrl
	import lpw_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	input  wire logic [7:0]       avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [31:0]      avs_writedata,
	input  wire logic [3:0]       avs_byteenable,
	output logic      [31:0]      avs_readdata,
	output logic                  avs_waitrequest,
	input  wire logic             resetPin,
	input  wire logic             rtcSecondAlarmFlag,
	input  wire lpw_wake_src_type wakeSrc,
	output logic                  rtcWakeIrq,
	output lpw_power_type         power
);

	////////////////////////////////////////////////////////////////////////////////
	// State
	lpw_state_type          state;
	lpw_state_type          next_state;
	logic [RST_CNT_W-1:0]   rstCnt;
	logic [RST_CNT_W-1:0]   next_rstCnt;
	logic [SEF_W-1:0]       startEnableFirst;
	logic [SEF_W-1:0]       next_startEnableFirst;
	logic [PIN_N-1:0]       startEnableSecond;
	logic [PIN_N-1:0]       next_startEnableSecond;
	logic [BOD_W-1:0]       brownoutControl;
	logic [BOD_W-1:0]       next_brownoutControl;
	logic [CAUSE_W-1:0]     wakeCause;
	logic [CAUSE_W-1:0]     next_wakeCause;
	logic [31:0]            next_readdata;
	logic                   next_waitrequest;
	logic                   next_rtcWakeIrq;
	lpw_power_type          next_power;
	logic                   writeFire;
	logic                   modeReq;
	logic [1:0]             modeCode;
	logic                   regClear;
	logic                   sleepWake;
	logic                   deepWake;
	logic                   dpdWake;
	logic                   resetEvent;
	logic                   pinWake;
	logic                   serialWake;

	////////////////////////////////////////////////////////////////////////////////
	// Wake qualification

	always_comb begin
		// Any enabled pin may wake; the group enable covers all eight at once
		pinWake = |(wakeSrc.pinIrq & (startEnableSecond
			| {PIN_N{startEnableFirst[SEF_PINS]}}));
		serialWake =
			(wakeSrc.uartIrq & (wakeSrc.uartSyncSlave | wakeSrc.uart32k)
				& startEnableFirst[SEF_UART])
			| (wakeSrc.spiIrq & wakeSrc.spiSlave & startEnableFirst[SEF_SPI])
			| (wakeSrc.i2cIrq & wakeSrc.i2cSlave & startEnableFirst[SEF_I2C]);
		sleepWake = wakeSrc.nvicIrq
			| wakeSrc.hardwareWake
			| rtcWakeIrq;
		deepWake = pinWake | serialWake
			| wakeSrc.hardwareWake
			| (wakeSrc.brownoutIrq & brownoutControl[BOD_IRQ_EN]
				& startEnableFirst[SEF_BOD])
			| (wakeSrc.watchdogIrq & startEnableFirst[SEF_WDT])
			| (rtcWakeIrq & startEnableFirst[SEF_RTC_ALARM])
			| (wakeSrc.rtcWakeTimeout & startEnableFirst[SEF_RTC_WAKE])
			| (wakeSrc.microtickIrq & startEnableFirst[SEF_MICROTICK_TIMER])
			| (wakeSrc.usb0NeedClk & startEnableFirst[SEF_USB0])
			| (wakeSrc.usb1NeedClk & startEnableFirst[SEF_USB1])
			| (wakeSrc.ethIrq & startEnableFirst[SEF_ETH])
			| (wakeSrc.dmaIrq & startEnableFirst[SEF_DMA]);
		// Only the always-on domain can end power-down
		dpdWake = rtcWakeIrq | wakeSrc.rtcWakeTimeout;
		// Brownout reset is dropped unless enabled, in every powered mode
		resetEvent = resetPin
			| (wakeSrc.brownoutReset & brownoutControl[BOD_RST_EN])
			| wakeSrc.watchdogReset;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode state machine

	always_comb begin
		next_state = state;
		next_rstCnt = rstCnt;
		case (state)
			ST_ACTIVE: begin
				if (resetEvent) begin
					next_state = ST_RSTSEQ;
				end else if (modeReq && modeCode == MODE_SLEEP) begin
					next_state = ST_SLEEP;
				end else if (modeReq && modeCode == MODE_DSLEEP) begin
					next_state = ST_DSLEEP;
				end else if (modeReq && modeCode == MODE_DPD) begin
					next_state = ST_DPD;
				end
			end
			ST_SLEEP: begin
				if (resetEvent) begin
					next_state = ST_RSTSEQ;
				end else if (sleepWake) begin
					next_state = ST_ACTIVE;
				end
			end
			ST_DSLEEP: begin
				if (resetEvent) begin
					next_state = ST_RSTSEQ;
				end else if (deepWake) begin
					next_state = ST_ACTIVE;
				end
			end
			ST_DPD: begin
				// Brownout and watchdog are unpowered here, so of the reset sources only the pin counts
				if (resetPin || dpdWake) begin
					next_state = ST_RSTSEQ;
				end
			end
			ST_RSTSEQ: begin
				// Held while the reset pin stays asserted
				if (resetPin) begin
					next_rstCnt = '0;
				end else if (rstCnt == RST_CNT_W'(RST_SEQ_CYC - 1)) begin
					next_rstCnt = '0;
					next_state = ST_ACTIVE;
				end else begin
					next_rstCnt = rstCnt + RST_CNT_W'(1);
				end
			end
			default: begin
				next_state = ST_RSTSEQ;
				next_rstCnt = '0;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state <= ST_ACTIVE;
			rstCnt <= '0;
		end else begin
			state <= next_state;
			rstCnt <= next_rstCnt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power and clock controls, registered per mode

	always_comb begin
		next_power = '0;
		next_power.domainPowerOn = 1'b1;
		next_power.periphClkEn = 1'b1;
		next_power.pllOn = 1'b1;
		next_power.ethClkEn = 1'b1;
		next_power.serialClkEn = 1'b1;
		next_power.cpuClkEn = 1'b1;
		case (next_state)
			ST_SLEEP: begin
				next_power.cpuClkEn = 1'b0;
				next_power.stateHold = 1'b1;
			end
			ST_DSLEEP: begin
				next_power.cpuClkEn = 1'b0;
				next_power.stateHold = 1'b1;
				next_power.flashStandby = 1'b1;
				next_power.pllOn = 1'b0;
				next_power.ethClkEn = 1'b0;
				next_power.periphClkEn = 1'b0;
				// Serial units lose their clock but keep their slave wake path
				next_power.serialClkEn = 1'b0;
			end
			ST_DPD: begin
				next_power = '0;
				next_power.domainPowerOn = 1'b0;
				next_power.pinHighZ = 1'b1;
			end
			ST_RSTSEQ: begin
				next_power.cpuClkEn = 1'b0;
				next_power.domainReset = 1'b1;
			end
			default: begin
				next_power.cpuClkEn = 1'b1;
			end
		endcase
		next_rtcWakeIrq = rtcSecondAlarmFlag;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			power <= '0;
			rtcWakeIrq <= 1'b0;
		end else begin
			power <= next_power;
			rtcWakeIrq <= next_rtcWakeIrq;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait cycle, then a single answer cycle

	always_comb begin
		writeFire = avs_write & ~avs_waitrequest;
		modeReq = writeFire && avs_address == OFS_MODE && avs_byteenable[0];
		modeCode = avs_writedata[1:0];
		next_waitrequest = ~((avs_read | avs_write) & avs_waitrequest);
		next_readdata = avs_readdata;
		if (avs_read && avs_waitrequest) begin
			next_readdata = '0;
			case (avs_address)
				OFS_SEF:   next_readdata = 32'(startEnableFirst);
				OFS_SES:   next_readdata = 32'(startEnableSecond);
				OFS_BOD:   next_readdata = 32'(brownoutControl);
				OFS_STAT:  next_readdata = 32'(state);
				OFS_CAUSE: next_readdata = 32'(wakeCause);
				default:   next_readdata = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
		end else begin
			avs_waitrequest <= next_waitrequest;
			avs_readdata <= next_readdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Software registers, cleared again by every domain reset sequence

	always_comb begin
		regClear = state == ST_RSTSEQ;
		next_startEnableFirst = startEnableFirst;
		next_startEnableSecond = startEnableSecond;
		next_brownoutControl = brownoutControl;
		next_wakeCause = wakeCause;
		if (writeFire) begin
			case (avs_address)
				OFS_SEF: begin
					if (avs_byteenable[0]) next_startEnableFirst[7:0] = avs_writedata[7:0];
					if (avs_byteenable[1]) begin
						next_startEnableFirst[SEF_W-1:8] = avs_writedata[SEF_W-1:8];
					end
				end
				OFS_SES: begin
					if (avs_byteenable[0]) next_startEnableSecond = avs_writedata[PIN_N-1:0];
				end
				OFS_BOD: begin
					if (avs_byteenable[0]) next_brownoutControl = avs_writedata[BOD_W-1:0];
				end
				OFS_CAUSE: begin
					if (avs_byteenable[0]) begin
						next_wakeCause = wakeCause & ~avs_writedata[CAUSE_W-1:0];
					end
				end
				default: begin
					next_wakeCause = wakeCause;
				end
			endcase
		end
		// Setting after the clear so a wake in the clearing cycle survives
		if (state == ST_SLEEP && next_state == ST_ACTIVE) begin
			next_wakeCause[CAUSE_SLEEP] = 1'b1;
		end
		if (state == ST_DSLEEP && next_state == ST_ACTIVE) begin
			next_wakeCause[CAUSE_DSLEEP] = 1'b1;
		end
		if (regClear) begin
			next_startEnableFirst = SEF_RST;
			next_startEnableSecond = SES_RST;
			next_brownoutControl = BOD_RST;
			next_wakeCause = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			startEnableFirst <= SEF_RST;
			startEnableSecond <= SES_RST;
			brownoutControl <= BOD_RST;
			wakeCause <= '0;
		end else begin
			startEnableFirst <= next_startEnableFirst;
			startEnableSecond <= next_startEnableSecond;
			brownoutControl <= next_brownoutControl;
			wakeCause <= next_wakeCause;
		end
	end

endmodule // lpw_wake_ctrl

// File: sim/lpw_checker.sv
`timescale 1ns/100ps
module lpw_checker
	import lpw_pkg::*;
(
	input wire logic             ref_clk,
	input wire logic             sys_rst,
	input wire logic             avs_read,
	input wire logic             avs_write,
	input wire logic             avs_waitrequest,
	input wire logic             resetPin,
	input wire logic             rtcSecondAlarmFlag,
	input wire lpw_wake_src_type wakeSrc,
	input wire logic             rtcWakeIrq,
	input wire lpw_power_type    power
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered");
	a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_alarm_irq: assert property (
		!$past(sys_rst) |-> rtcWakeIrq == $past(rtcSecondAlarmFlag))
		else $error("alarm interrupt does not follow flag");
	// Power fields are all zero in reset, so the first edge after it is skipped
	a_dpd_off: assert property (
		!$past(sys_rst) && !power.domainPowerOn
		|-> power.pinHighZ && !power.cpuClkEn && !power.pllOn)
		else $error("power-down leaves something on");
	a_dsleep_off: assert property (
		power.flashStandby
		|-> !power.pllOn && !power.ethClkEn && !power.serialClkEn && !power.cpuClkEn)
		else $error("deep-sleep leaves a clock on");
	a_sleep_stop: assert property (power.stateHold |-> !power.cpuClkEn)
		else $error("processor clock runs while held");
	a_sleep_wake: assert property (
		power.stateHold && !power.flashStandby
		&& (wakeSrc.nvicIrq || wakeSrc.hardwareWake)
		|-> ##[1:2] (power.cpuClkEn || power.domainReset))
		else $error("sleep not ended by wake");
	a_dsleep_hw: assert property (
		power.flashStandby && wakeSrc.hardwareWake
		|-> ##[1:2] (power.cpuClkEn || power.domainReset))
		else $error("deep-sleep not ended by hardware wake");
	a_dpd_hold: assert property (
		!$past(sys_rst) && !power.domainPowerOn && !resetPin
		&& !rtcWakeIrq && !wakeSrc.rtcWakeTimeout |=> !power.domainPowerOn)
		else $error("power-down left without a legal source");
	a_rst_cpu: assert property (power.domainReset |-> !power.cpuClkEn)
		else $error("processor clocked during domain reset");
	a_rst_start: assert property ($rose(resetPin) |-> ##[1:2] power.domainReset)
		else $error("reset pin starts no domain reset");
endmodule // lpw_checker

// File: sim/lpw_src_model.sv
`timescale 1ns/100ps
module lpw_src_model
	import lpw_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire lpw_wake_src_type req,
	input  wire logic             reqPin,
	input  wire logic             reqAlarm,
	output lpw_wake_src_type      wakeSrc = '0,
	output logic                  resetPin = 1'b0,
	output logic                  rtcSecondAlarmFlag = 1'b0
);
	// Sources move only after an edge, as synchronised wake lines do
	always @(posedge ref_clk) begin
		wakeSrc            <= req;
		resetPin           <= reqPin;
		rtcSecondAlarmFlag <= reqAlarm;
	end
endmodule // lpw_src_model

// File: sim/tb.sv
`timescale 1ns/100ps
module tb
	import lpw_pkg::*;
;
	localparam logic [9:0] PWR_ACT = 10'h378;
	logic             ref_clk = 1'b0;
	logic             sys_rst = 1'b1;
	logic [7:0]       avs_address = 8'h00;
	logic             avs_read = 1'b0;
	logic             avs_write = 1'b0;
	logic [31:0]      avs_writedata = 32'h00000000;
	logic [31:0]      avs_readdata;
	logic             avs_waitrequest;
	logic             resetPin;
	logic             rtcSecondAlarmFlag;
	logic             rtcWakeIrq;
	logic             reqPin = 1'b0;
	logic             reqAlarm = 1'b0;
	lpw_wake_src_type req = '0;
	lpw_wake_src_type wakeSrc;
	lpw_wake_src_type tab [16];
	// Per table entry: processor clock expected back, domain reset expected
	logic [15:0]      wk = 16'h2F7C;
	logic [15:0]      rs = 16'hC000;
	lpw_power_type    power;
	logic [31:0]      q;
	int               error_cnt = 0;
	int               num_checks = 0;
	int               n;

	always #25 ref_clk = ~ref_clk;

	lpw_wake_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.resetPin(resetPin), .rtcSecondAlarmFlag(rtcSecondAlarmFlag), .wakeSrc(wakeSrc),
		.rtcWakeIrq(rtcWakeIrq), .power(power));
	lpw_src_model src (.ref_clk(ref_clk), .req(req), .reqPin(reqPin), .reqAlarm(reqAlarm),
		.wakeSrc(wakeSrc), .resetPin(resetPin), .rtcSecondAlarmFlag(rtcSecondAlarmFlag));
	////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task end_of_test;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask

	// One idle edge after each access, so the strobe is never set twice in one step
	task acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0 && i < 10) begin
			@(posedge ref_clk);
			i++;
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		if (i == 10) begin
			error_cnt++;
			end_of_test;
		end
		@(posedge ref_clk);
	endtask

	task wait_cpu;
		n = 0;
		while (power.cpuClkEn !== 1'b1 && n < 40) begin
			cyc(1);
			n++;
		end
		if (n == 40) begin
			error_cnt++;
			end_of_test;
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		tab = '{default: '0};
		tab[0].i2cIrq = 1'b1;
		tab[1].brownoutReset = 1'b1;
		tab[2].i2cIrq = 1'b1;
		tab[2].i2cSlave = 1'b1;
		tab[3].brownoutIrq = 1'b1;
		tab[4].hardwareWake = 1'b1;
		tab[5].uartIrq = 1'b1;
		tab[5].uartSyncSlave = 1'b1;
		tab[6].usb0NeedClk = 1'b1;
		tab[7].spiIrq = 1'b1;
		tab[8].watchdogIrq = 1'b1;
		tab[9].rtcWakeTimeout = 1'b1;
		tab[11].microtickIrq = 1'b1;
		tab[12].pinIrq = 8'h01;
		tab[13].pinIrq = 8'h08;
		tab[14].brownoutReset = 1'b1;
		tab[15].watchdogReset = 1'b1;
		cyc(3);
		sys_rst <= 1'b0;
		cyc(2);
		chk({22'h0, power}, {22'h0, PWR_ACT});
		acc(1'b0, OFS_SEF, 32'h0);
		chk(q, 32'h0);
		// Software enables the single-source wakes from BOD to USB0; USB1, ETH, DMA and the pin group bit stay off
		acc(1'b1, OFS_SEF, 32'h000001FF);
		acc(1'b1, OFS_SES, 32'h00000008);
		acc(1'b1, OFS_BOD, 32'h00000002);
		acc(1'b0, OFS_SEF, 32'h0);
		chk(q, 32'h000001FF);
		acc(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		acc(1'b1, OFS_MODE, 32'h00000001);
		cyc(2);
		chk({power.cpuClkEn, power.stateHold}, 32'h1);
		req.nvicIrq <= 1'b1;
		wait_cpu;
		chk(power.cpuClkEn, 32'h1);
		req <= '0;
		acc(1'b0, OFS_CAUSE, 32'h0);
		chk(q[1:0], 32'h1);
		acc(1'b1, OFS_CAUSE, 32'h00000001);
		acc(1'b0, OFS_CAUSE, 32'h0);
		chk(q[1:0], 32'h0);
		// The two reset entries come last, since each clears every register
		for (int k = 0; k < 16; k++) begin
			if (k >= 14) begin
				wait_cpu;
				acc(1'b0, OFS_CAUSE, 32'h0);
				chk(q[1:0], {30'h0, k == 14, 1'b0});
				acc(1'b1, OFS_BOD, 32'h00000001);
			end
			acc(1'b1, OFS_MODE, 32'h00000002);
			cyc(2);
			chk(power.flashStandby, 32'h1);
			chk({power.pllOn, power.ethClkEn, power.serialClkEn}, 32'h0);
			req <= tab[k];
			reqAlarm <= (k == 10);
			cyc(5);
			chk({power.cpuClkEn, power.domainReset}, {30'h0, wk[k], rs[k]});
			req <= '0;
			reqAlarm <= 1'b0;
			cyc(2);
		end
		wait_cpu;
		acc(1'b0, OFS_STAT, 32'h0);
		chk(q, 32'h00000001);
		acc(1'b1, OFS_SEF, 32'h000001FF);
		acc(1'b1, OFS_MODE, 32'h00000003);
		cyc(2);
		chk({power.domainPowerOn, power.pinHighZ, power.cpuClkEn}, 32'h2);
		req.nvicIrq <= 1'b1;
		req.hardwareWake <= 1'b1;
		cyc(5);
		chk(power.domainPowerOn, 32'h0);
		req <= '0;
		reqAlarm <= 1'b1;
		cyc(3);
		chk(rtcWakeIrq, 32'h1);
		reqAlarm <= 1'b0;
		cyc(1);
		chk(power.domainReset, 32'h1);
		wait_cpu;
		chk({22'h0, power}, {22'h0, PWR_ACT});
		acc(1'b0, OFS_SEF, 32'h0);
		chk(q, 32'h0);
		reqPin <= 1'b1;
		cyc(3);
		chk(power.domainReset, 32'h1);
		reqPin <= 1'b0;
		n = 0;
		while (power.domainReset === 1'b1 && n < 40) begin
			cyc(1);
			n++;
		end
		// Two edges of model and sampling delay lie between the drop and the count start
		chk(n >= RST_SEQ_CYC && n <= RST_SEQ_CYC + 4, 32'h1);
		end_of_test;
	end
endmodule // tb

bind lpw_wake_ctrl lpw_checker u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.resetPin(resetPin), .rtcSecondAlarmFlag(rtcSecondAlarmFlag), .wakeSrc(wakeSrc),
	.rtcWakeIrq(rtcWakeIrq), .power(power));
